// *** hw/hcp_dev_end.sv ***
/*
 * hcp_dev_end: device end of the host cpu port. Decodes host strobes,
 * issues one request per access to internal logic, answers with ready
 * or transfer ack. Assumes the host keeps address and write data stable
 * for the whole access and leaves the required gap between accesses.
 */

// Functional notes
// RULE1: read starts with select and read strobe
// RULE2: read ends when select or strobe drops
// RULE3: write starts with select and write strobe
// RULE4: write ends when select or strobe drops
// RULE5: host leaves four clocks between accesses
// RULE6: ready drops promptly once an access starts
// RULE7: answer between six and sixty clocks
// RULE8: read data one clock before ready
// RULE9: host holds strobes until ready; data early
// RULE10: ack driven high soon after strobe
// RULE11: read data one clock before ack
// RULE12: ack driven high, then released
// RULE13: read data held briefly, then released
// RULE14: space select routes to registers or memory
// RULE15: one strobe style, fixed by configuration
`timescale 1ns/100ps
`default_nettype none
module hcp_dev_end
  import hcp_pkg::*;
#(
  parameter int unsigned STYLE = STYLE_RDWR,
  parameter int unsigned DW    = 16,
  parameter int unsigned AW    = 15
) (
  input  wire logic          I_CLK_SYS,
  input  wire logic          I_RST,
  hcp_if.dev                 bus,
  output logic               O_REG_REQ,
  output logic               O_MEM_REQ,
  output logic               O_WRITE,
  output logic [AW-1:0]      O_ADDR,
  output logic [DW-1:0]      O_WDATA,
  input  wire logic          I_DONE,
  input  wire logic [DW-1:0] I_RDATA,
  output logic               O_TIMEOUT
);
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_DATA, ST_ACK, ST_HOLD} hcp_state_t;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int unsigned SW = AW + DW + 6;
  logic [SW-1:0]    sync1_q;
  logic [SW-1:0]    sync2_q;
  hcp_state_t       state_q;
  hcp_state_t       state_d;
  logic [CNT_W-1:0] cnt_q;
  logic             is_rd_q;
  logic             done_q;
  logic [DW-1:0]    rdata_q;
  logic             reg_req_q;
  logic             mem_req_q;
  logic             wr_q;
  logic [AW-1:0]    addr_q;
  logic [DW-1:0]    wdata_q;
  logic             tmo_q;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  // every host pin passes two flops; all bits share the same delay so
  // address and data line up with the strobes that qualify them
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      sync1_q <= {SW{1'b1}};
      sync2_q <= {SW{1'b1}};
    end else begin
      sync1_q <= {bus.cs_n, bus.rd_n, bus.wr_n, bus.ds_n, bus.rw, bus.mem_sel,
                  bus.addr, bus.data_line};
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // strobe decode
  // ----------------------------------------------------------------
  wire            cs_n_s   = sync2_q[SW-1];
  wire            rd_n_s   = sync2_q[SW-2];
  wire            wr_n_s   = sync2_q[SW-3];
  wire            ds_n_s   = sync2_q[SW-4];
  wire            rw_s     = sync2_q[SW-5];
  wire            msel_s   = sync2_q[SW-6];
  wire [AW-1:0]   addr_s   = sync2_q[DW+AW-1:DW];
  wire [DW-1:0]   data_s   = sync2_q[DW-1:0];
  wire            sty_rdwr = (STYLE == STYLE_RDWR);           // see RULE15
  // both strobes low at once is illegal and never starts an access
  wire            rdwr_go  = !cs_n_s && (rd_n_s ^ wr_n_s);    // see RULE1 see RULE3
  wire            dstb_go  = !cs_n_s && !ds_n_s;
  wire            start    = sty_rdwr ? rdwr_go : dstb_go;
  wire            start_rd = sty_rdwr ? !rd_n_s : rw_s;
  // the access ends on whichever of select or strobe rises first
  wire            rdwr_end = cs_n_s || (is_rd_q ? rd_n_s : wr_n_s);  // see RULE2 see RULE4
  wire            dstb_end = cs_n_s || ds_n_s;
  wire            end_det  = sty_rdwr ? rdwr_end : dstb_end;
  wire            done_any = done_q || I_DONE;
  wire            min_ok   = (cnt_q >= DATA_AT_CYC);          // see RULE7
  wire            tmo_hit  = (cnt_q >= DEV_TMO_CYC);          // see RULE7

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  // data stage precedes the answer stage by one clock unless select or strobe drops first
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (start) state_d = ST_WAIT;
      ST_WAIT: begin
        if (end_det) state_d = ST_HOLD;                       // aborted early
        else if ((done_any && min_ok) || tmo_hit) state_d = ST_DATA;
      end
      ST_DATA: state_d = end_det ? ST_HOLD : ST_ACK;          // see RULE8 see RULE11
      ST_ACK:  if (end_det) state_d = ST_HOLD;
      ST_HOLD: state_d = ST_IDLE;                             // see RULE12 see RULE13
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) state_q <= ST_IDLE;
    else       state_q <= state_d;
  end

  // ----------------------------------------------------------------
  // latency counter
  // ----------------------------------------------------------------
  // starts at the synchroniser depth so it tracks time since the pins moved
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST)                  cnt_q <= '0;
    else if (state_q == ST_IDLE) cnt_q <= CNT_START;
    else if (cnt_q != {CNT_W{1'b1}}) cnt_q <= cnt_q + CNT_W'(1);
  end

  // ----------------------------------------------------------------
  // request capture towards internal logic
  // ----------------------------------------------------------------
  wire take = (state_q == ST_IDLE) && start;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      reg_req_q <= 1'b0;
      mem_req_q <= 1'b0;
      wr_q      <= 1'b0;
      is_rd_q   <= 1'b0;
      addr_q    <= '0;
      wdata_q   <= '0;
    end else begin
      reg_req_q <= take && !msel_s;                           // see RULE14
      mem_req_q <= take && msel_s;                            // see RULE14
      if (take) begin
        is_rd_q <= start_rd;
        wr_q    <= !start_rd;
        addr_q  <= addr_s;
        wdata_q <= data_s;      // write data is valid when the strobe is seen
      end
    end
  end

  // ----------------------------------------------------------------
  // completion and read data
  // ----------------------------------------------------------------
  // a late answer after timeout is dropped; internal logic must not rely
  // on the host having seen it
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      done_q  <= 1'b0;
      rdata_q <= '0;
      tmo_q   <= 1'b0;
    end else begin
      tmo_q <= (state_q == ST_WAIT) && !end_det && tmo_hit && !done_any;
      if (state_q == ST_IDLE) begin
        done_q <= 1'b0;
      end else if (state_q == ST_WAIT && I_DONE && !done_q) begin
        done_q  <= 1'b1;
        rdata_q <= I_RDATA;
      end else if (state_q == ST_WAIT && tmo_hit && !done_any) begin
        rdata_q <= TMO_RDATA[DW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  wire busy_low = (state_q == ST_WAIT) || (state_q == ST_DATA);
  wire drv_data = is_rd_q && ((state_q == ST_DATA) || (state_q == ST_ACK) ||
                              (state_q == ST_HOLD));
  wire ack_drv  = !sty_rdwr && (state_q != ST_IDLE);
  assign bus.ready    = !(sty_rdwr && busy_low);                  // see RULE6
  assign bus.ack_n    = !(state_q == ST_ACK);                     // see RULE7
  assign bus.ack_oe_n = !ack_drv;                                 // see RULE10 see RULE12
  assign bus.dd       = rdata_q;
  assign bus.dd_oe_n  = !drv_data;                                // see RULE13

  // ----------------------------------------------------------------
  // user side
  // ----------------------------------------------------------------
  assign O_REG_REQ = reg_req_q;
  assign O_MEM_REQ = mem_req_q;
  assign O_WRITE   = wr_q;
  assign O_ADDR    = addr_q;
  assign O_WDATA   = wdata_q;
  assign O_TIMEOUT = tmo_q;
endmodule
`default_nettype wire

// *** hw/hcp_pkg.sv ***
/*
 * hcp_pkg: shared constants of the host cpu port handshake.
 * Assumes both ends run on the same 25 MHz master clock (40 ns).
 */
`default_nettype none
package hcp_pkg;
  // ----------------------------------------------------------------
  // strobe styles
  // ----------------------------------------------------------------
  localparam int unsigned STYLE_RDWR = 0;   // separate read / write strobes, ready line
  localparam int unsigned STYLE_DSTB = 1;   // data strobe + direction, transfer ack

  // ----------------------------------------------------------------
  // timing, in master clock periods and derived cycle counts
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned ACK_MIN_MCLK   = 6;    // completion strictly later than this
  localparam int unsigned ACK_MAX_MCLK   = 60;   // completion strictly earlier than this
  localparam int unsigned ACC_GAP_MCLK   = 4;    // idle time between host accesses
  localparam int unsigned SYNC_CYC       = 2;    // pin synchroniser depth
  localparam int unsigned CNT_W          = 7;
  localparam logic [CNT_W-1:0] DATA_AT_CYC = CNT_W'(ACK_MIN_MCLK + 1 - 1);
  localparam logic [CNT_W-1:0] DEV_TMO_CYC = CNT_W'(ACK_MAX_MCLK - 4);
  localparam logic [CNT_W-1:0] CNT_START   = CNT_W'(SYNC_CYC);
  localparam logic [CNT_W-1:0] HOST_GAP_CYC = CNT_W'(ACC_GAP_MCLK + SYNC_CYC);
  localparam logic [CNT_W-1:0] HOST_TMO_CYC = CNT_W'(ACK_MAX_MCLK + 8);
  localparam logic [15:0]      TMO_RDATA    = 16'h0000;
endpackage
`default_nettype wire

// *** hw/hcp_if.sv ***
/*
 * hcp_if: pins between the host cpu and the device port.
 * Assumes a pull-up on shared lines: undriven data and ack read as ones.
 */
`timescale 1ns/100ps
`default_nettype none
interface hcp_if #(
  parameter int unsigned DW = 16,
  parameter int unsigned AW = 15
);
  logic          cs_n;
  logic          rd_n;
  logic          wr_n;
  logic          ds_n;
  logic          rw;          // high = read, data-strobe style only
  logic          mem_sel;     // memory_space_select: high = external memory
  logic [AW-1:0] addr;
  logic [DW-1:0] hd;          // host data out
  logic          hd_oe_n;
  logic [DW-1:0] dd;          // device data out
  logic          dd_oe_n;
  logic          ready;
  logic          ack_n;       // transfer_ack_n drive value
  logic          ack_oe_n;
  wire  [DW-1:0] data_line;
  wire           ack_line;

  // ----------------------------------------------------------------
  // wire resolution with pull-ups
  // ----------------------------------------------------------------
  assign data_line = !dd_oe_n ? dd : (!hd_oe_n ? hd : {DW{1'b1}});
  assign ack_line  = ack_oe_n ? 1'b1 : ack_n;

  modport dev  (input cs_n, rd_n, wr_n, ds_n, rw, mem_sel, addr, data_line,
                output dd, dd_oe_n, ready, ack_n, ack_oe_n);
  modport host (input ready, ack_line, data_line,
                output cs_n, rd_n, wr_n, ds_n, rw, mem_sel, addr, hd, hd_oe_n);
endinterface
`default_nettype wire

// *** hw/hcp_host_end.sv ***
/*
 * hcp_host_end: host cpu end. Runs one access per request, waits for
 * the device answer, then keeps the bus idle before the next one.
 * Assumes the device end shares the strobe style parameter.
 */
`timescale 1ns/100ps
`default_nettype none
module hcp_host_end
  import hcp_pkg::*;
#(
  parameter int unsigned STYLE = STYLE_RDWR,
  parameter int unsigned DW    = 16,
  parameter int unsigned AW    = 15
) (
  input  wire logic          I_CLK_SYS,
  input  wire logic          I_RST,
  hcp_if.host                bus,
  input  wire logic          I_REQ,
  input  wire logic          I_WRITE,
  input  wire logic          I_MEM,
  input  wire logic [AW-1:0] I_ADDR,
  input  wire logic [DW-1:0] I_WDATA,
  output logic               O_BUSY,
  output logic               O_DONE,
  output logic [DW-1:0]      O_RDATA,
  output logic               O_TIMEOUT
);
  typedef enum logic [1:0] {HS_IDLE, HS_ACC, HS_GAP} hcp_hstate_t;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  hcp_hstate_t      st_q;
  logic [CNT_W-1:0] cnt_q;
  logic [DW+1:0]    s1_q;
  logic [DW+1:0]    s2_q;
  logic             seen_low_q;
  logic             wr_q;
  logic             mem_q;
  logic [AW-1:0]    addr_q;
  logic [DW-1:0]    wdata_q;
  logic [DW-1:0]    rdata_q;
  logic             done_q;
  logic             tmo_q;

  // ----------------------------------------------------------------
  // answer synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      s1_q <= {(DW+2){1'b1}};
      s2_q <= {(DW+2){1'b1}};
    end else begin
      s1_q <= {bus.ready, bus.ack_line, bus.data_line};
      s2_q <= s1_q;
    end
  end

  // ----------------------------------------------------------------
  // answer decode
  // ----------------------------------------------------------------
  wire sty_rdwr = (STYLE == STYLE_RDWR);
  wire rdy_s    = s2_q[DW+1];
  wire ack_s    = s2_q[DW];
  // ready high is only an answer after it was seen low in this access
  wire answered = sty_rdwr ? (seen_low_q && rdy_s) : !ack_s;   // see RULE9
  wire timed    = (cnt_q >= HOST_TMO_CYC);
  wire finish   = (st_q == HS_ACC) && (answered || timed);

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      st_q       <= HS_IDLE;
      cnt_q      <= '0;
      seen_low_q <= 1'b0;
      wr_q       <= 1'b0;
      mem_q      <= 1'b0;
      addr_q     <= '0;
      wdata_q    <= '0;
      rdata_q    <= '0;
      done_q     <= 1'b0;
      tmo_q      <= 1'b0;
    end else begin
      done_q <= finish;
      tmo_q  <= finish && !answered;
      unique case (st_q)
        HS_IDLE: if (I_REQ) begin                             // see RULE1 see RULE3
          st_q       <= HS_ACC;
          cnt_q      <= '0;
          seen_low_q <= 1'b0;
          wr_q       <= I_WRITE;
          mem_q      <= I_MEM;                                // see RULE14
          addr_q     <= I_ADDR;
          wdata_q    <= I_WDATA;
        end
        HS_ACC: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (!rdy_s) seen_low_q <= 1'b1;
          if (finish) begin
            st_q  <= HS_GAP;
            cnt_q <= '0;
            if (!wr_q) rdata_q <= s2_q[DW-1:0];               // see RULE8
          end
        end
        HS_GAP: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (cnt_q >= HOST_GAP_CYC) st_q <= HS_IDLE;         // see RULE5
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  wire act = (st_q == HS_ACC);
  assign bus.cs_n    = !act;
  assign bus.rd_n    = !(act && sty_rdwr && !wr_q);
  assign bus.wr_n    = !(act && sty_rdwr && wr_q);
  assign bus.ds_n    = !(act && !sty_rdwr);
  assign bus.rw      = !wr_q;
  assign bus.mem_sel = mem_q;
  assign bus.addr    = addr_q;
  assign bus.hd      = wdata_q;
  assign bus.hd_oe_n = !(act && wr_q);                        // see RULE9

  assign O_BUSY    = (st_q != HS_IDLE);
  assign O_DONE    = done_q;
  assign O_RDATA   = rdata_q;
  assign O_TIMEOUT = tmo_q;
endmodule
`default_nettype wire

// *** tb/hcp_assertions.sv ***
/*
 * hcp_assertions: pin-level checks on the link between host and device ends.
 * Assumes the watched pair runs in the separate read / write strobe style.
 */
`timescale 1ns/100ps
`default_nettype none
module hcp_assertions (
  input  wire logic I_CLK_SYS,
  input  wire logic I_RST,
  input  wire logic cs_n,
  input  wire logic rd_n,
  input  wire logic wr_n,
  input  wire logic mem_sel,
  input  wire logic hd_oe_n,
  input  wire logic dd_oe_n,
  input  wire logic ready,
  input  wire logic ack_oe_n
);
  // ----------------------------------------------------------------
  // access qualifier
  // ----------------------------------------------------------------
  wire act;
  assign act = !cs_n && (!rd_n || !wr_n);

  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  // ----------------------------------------------------------------
  // handshake timing
  // ----------------------------------------------------------------
  chk_ready_drop: assert property ($rose(act) |-> ##[1:4] !ready)
    else $error("ready not dropped after strobe");
  chk_ready_early: assert property ($rose(act) |-> (!$rose(ready)) [*7])
    else $error("ready returned too early");
  chk_ready_late: assert property ($rose(act) |-> ##[6:60] $rose(ready))
    else $error("ready returned too late");
  chk_data_first: assert property ($rose(ready) && !rd_n |-> $past(dd_oe_n) == 1'b0)
    else $error("read data not driven before ready");
  chk_write_quiet: assert property (!cs_n && !wr_n |-> dd_oe_n)
    else $error("device drove data on write");
  chk_read_hold: assert property ($rose(cs_n) && !dd_oe_n |=> !dd_oe_n)
    else $error("read data dropped at once");
  chk_end_idle: assert property ($rose(cs_n) |-> ##[1:5] (ready && dd_oe_n))
    else $error("device did not return to idle");
  chk_host_holds: assert property ($rose(cs_n) |-> $past(ready))
    else $error("host dropped strobe before ready");
  chk_wdata_held: assert property (!cs_n && !wr_n |-> !hd_oe_n)
    else $error("write data not driven");
  chk_ack_unused: assert property (ack_oe_n)
    else $error("ack driven in read / write style");
  chk_space_stable: assert property (!cs_n && $past(!cs_n) |-> $stable(mem_sel))
    else $error("space select moved in access");

  // main scenarios reached
  cov_read: cover property ($rose(ready) && !rd_n);
  cov_write: cover property ($rose(ready) && !wr_n);
  cov_mem: cover property ($rose(act) && mem_sel);
endmodule
`default_nettype wire

// *** tb/tb_host_cpu_port_handshake.sv ***
/*
 * tb_host_cpu_port_handshake: host and device ends face each other on if_a;
 * a second device end in data strobe style on if_b is driven by the bench;
 * a third pair in data strobe style faces each other on if_c.
 * Assumes the internal side answers within 40 cycles.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_host_cpu_port_handshake;
  import hcp_pkg::*;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             h_req, h_wr, h_mem;
  logic [14:0]      h_addr;
  logic [15:0]      h_wdata;
  logic [2:0]       x_kind [3] = '{default: 3'h0};
  logic [14:0]      x_addr [3] = '{default: 15'h0000};
  logic [15:0]      x_wd   [3] = '{default: 16'h0000};
  wire  [1:0]       h_busy, h_done, h_tmo;
  wire  [1:0][15:0] h_rdata;
  wire  [2:0]       rreq, mreq, wrt, tmo;
  wire  [2:0][14:0] daddr;
  wire  [2:0][15:0] dwd;
  logic [2:0]       done = 3'b000;
  logic [15:0]      rdat [3] = '{default: 16'h0000};
  int               dly [3] = '{default: 0};
  int               failures, n_compared;

  hcp_if if_a ();
  hcp_if if_b ();
  hcp_host_end #(.STYLE(STYLE_RDWR)) u_hcp_host_end (.I_CLK_SYS(clk), .I_RST(rst),
    .bus(if_a.host), .I_REQ(h_req), .I_WRITE(h_wr), .I_MEM(h_mem), .I_ADDR(h_addr),
    .I_WDATA(h_wdata), .O_BUSY(h_busy[0]), .O_DONE(h_done[0]), .O_RDATA(h_rdata[0]),
    .O_TIMEOUT(h_tmo[0]));
  hcp_dev_end #(.STYLE(STYLE_RDWR)) u_hcp_dev_end (.I_CLK_SYS(clk), .I_RST(rst),
    .bus(if_a.dev), .O_REG_REQ(rreq[0]), .O_MEM_REQ(mreq[0]), .O_WRITE(wrt[0]),
    .O_ADDR(daddr[0]), .O_WDATA(dwd[0]), .I_DONE(done[0]), .I_RDATA(rdat[0]), .O_TIMEOUT(tmo[0]));
  hcp_dev_end #(.STYLE(STYLE_DSTB)) u_hcp_dev_end_b (.I_CLK_SYS(clk), .I_RST(rst),
    .bus(if_b.dev), .O_REG_REQ(rreq[1]), .O_MEM_REQ(mreq[1]), .O_WRITE(wrt[1]),
    .O_ADDR(daddr[1]), .O_WDATA(dwd[1]), .I_DONE(done[1]), .I_RDATA(rdat[1]), .O_TIMEOUT(tmo[1]));
  // data strobe pair: both ends are design code and share the host request inputs
  hcp_if if_c ();
  hcp_host_end #(.STYLE(STYLE_DSTB)) u_hcp_host_end_c (.I_CLK_SYS(clk), .I_RST(rst),
    .bus(if_c.host), .I_REQ(h_req), .I_WRITE(h_wr), .I_MEM(h_mem), .I_ADDR(h_addr),
    .I_WDATA(h_wdata), .O_BUSY(h_busy[1]), .O_DONE(h_done[1]), .O_RDATA(h_rdata[1]),
    .O_TIMEOUT(h_tmo[1]));
  hcp_dev_end #(.STYLE(STYLE_DSTB)) u_hcp_dev_end_c (.I_CLK_SYS(clk), .I_RST(rst),
    .bus(if_c.dev), .O_REG_REQ(rreq[2]), .O_MEM_REQ(mreq[2]), .O_WRITE(wrt[2]),
    .O_ADDR(daddr[2]), .O_WDATA(dwd[2]), .I_DONE(done[2]), .I_RDATA(rdat[2]), .O_TIMEOUT(tmo[2]));
  hcp_assertions u_hcp_assertions (.I_CLK_SYS(clk), .I_RST(rst), .cs_n(if_a.cs_n),
    .rd_n(if_a.rd_n), .wr_n(if_a.wr_n), .mem_sel(if_a.mem_sel), .hd_oe_n(if_a.hd_oe_n),
    .dd_oe_n(if_a.dd_oe_n), .ready(if_a.ready), .ack_oe_n(if_a.ack_oe_n));

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] rdfun(input logic [14:0] a);
    return {a[6:0], ~a[14:6]} ^ 16'hC35A;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // internal side: answers each request after a random delay
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      done[i] <= !(rreq[i] || mreq[i]) && (dly[i] == 1);
      if (rreq[i] || mreq[i]) begin
        dly[i] <= $urandom_range(40, 1);
      end else if (dly[i] == 1) begin
        rdat[i] <= rdfun(daddr[i]);
        dly[i]  <= 0;
      end else if (dly[i] > 1) begin
        dly[i] <= dly[i] - 1;
      end
    end
  end

  // routing of each access; registered values read one edge late;
  // outputs are unknown until reset has passed, so reset time is skipped
  always @(posedge clk) begin
    if (!rst) begin
      if (tmo !== 3'b000) check(32'(tmo), 32'h0);
      for (int i = 0; i < 3; i++) begin
        if (rreq[i] || mreq[i]) begin
          check({mreq[i], rreq[i], wrt[i], daddr[i]}, {x_kind[i], x_addr[i]});
          if (x_kind[i][0]) check(32'(dwd[i]), 32'(x_wd[i]));
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic host_acc(input logic w, input logic m, input logic [14:0] a,
                          input logic [15:0] d);
    int         n;
    logic [1:0] got;
    x_kind[0] = {m, !m, w};
    x_kind[2] = {m, !m, w};
    x_addr[0] = a;
    x_addr[2] = a;
    x_wd[0]   = d;
    x_wd[2]   = d;
    @(posedge clk);
    h_req <= 1'b1; h_wr <= w; h_mem <= m; h_addr <= a; h_wdata <= d;
    @(posedge clk);
    h_req <= 1'b0;
    n   = 0;
    got = 2'b00;
    // both hosts run the same access; each done pulse is looked at once
    while (got !== 2'b11 && n < 200) begin
      @(posedge clk);
      n++;
      for (int k = 0; k < 2; k++) begin
        if (h_done[k] === 1'b1) begin
          got[k] = 1'b1;
          check(32'(h_tmo[k]), 32'h0);
          if (!w) check(32'(h_rdata[k]), 32'(rdfun(a)));
        end
      end
    end
    if (got !== 2'b11) begin failures++; finish_test(); end
    n = 0;
    while (h_busy !== 2'b00 && n < 50) begin @(posedge clk); n++; end
    if (n >= 50) begin failures++; finish_test(); end
  endtask

  // data strobe access; cut below 200 drops the strobes before the answer
  task automatic dev_b_acc(input logic rd, input logic [14:0] a, input logic [15:0] d,
                           input int cut);
    int   n;
    logic pd, hi;
    x_kind[1] = {a[0], !a[0], !rd};
    x_addr[1] = a;
    x_wd[1]   = d;
    @(posedge clk);
    if_b.cs_n <= 1'b0; if_b.ds_n <= 1'b0; if_b.rw <= rd; if_b.addr <= a;
    if_b.mem_sel <= a[0]; if_b.hd <= d; if_b.hd_oe_n <= rd;
    repeat (5) @(posedge clk);
    check({if_b.ack_oe_n, if_b.ack_line}, 2'b01);
    n  = 5;
    pd = 1'b1;
    while (if_b.ack_line !== 1'b0 && n < cut) begin pd = if_b.dd_oe_n; @(posedge clk); n++; end
    if (cut < 200) begin
      check(32'(if_b.ack_line), 32'h1);
    end else begin
      check(32'(n >= 7 && n <= 61), 32'h1);
      if (rd) check({pd, if_b.data_line}, {1'b0, rdfun(a)});
    end
    if_b.cs_n <= 1'b1; if_b.ds_n <= 1'b1; if_b.hd_oe_n <= 1'b1; if_b.hd <= ~d;
    hi = 1'b0;
    repeat (6) begin
      @(posedge clk);
      if (if_b.ack_oe_n === 1'b0 && if_b.ack_n === 1'b1) hi = 1'b1;
    end
    check({hi, if_b.ack_oe_n, if_b.dd_oe_n}, 3'b111);
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    failures = 0; n_compared = 0;
    h_req = 1'b0; h_wr = 1'b0; h_mem = 1'b0; h_addr = 15'h0000; h_wdata = 16'h0000;
    if_b.cs_n = 1'b1; if_b.ds_n = 1'b1; if_b.rd_n = 1'b1; if_b.wr_n = 1'b1; if_b.rw = 1'b1;
    if_b.mem_sel = 1'b0; if_b.addr = 15'h0000; if_b.hd = 16'h0000; if_b.hd_oe_n = 1'b1;
    void'($urandom(38959));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // corners: extreme addresses and data, both spaces, write then read back to back
    host_acc(1'b1, 1'b0, 15'h7FFF, 16'hFFFF);
    host_acc(1'b0, 1'b0, 15'h7FFF, 16'h0000);
    host_acc(1'b0, 1'b1, 15'h0000, 16'h0000);
    host_acc(1'b1, 1'b1, 15'h0000, 16'h0000);
    repeat (30) host_acc(1'($urandom), 1'($urandom), 15'($urandom), 16'($urandom));
    for (int i = 0; i < 6; i++) dev_b_acc(i[0], 15'($urandom), 16'($urandom), (i > 3) ? 5 : 200);
    finish_test();
  end
endmodule
`default_nettype wire
